// File: rtl/eepr_top.sv
// two-wire serial eeprom command engine with array and page buffer
`timescale 1ns/1ps
module eepr_top #(
    parameter int unsigned ADDR_W      = eepr_pkg::ADDR_W_DEF,  // 9 or 10
    parameter int unsigned PROG_CYCLES = eepr_pkg::PROG_CYCLES  // programming length
) (
    input  wire logic SYS_CLK_I,            // system clock
    input  wire logic RST_I,                // synchronous reset
    input  wire logic SCL_I,                // serial clock pin
    input  wire logic SDA_I,                // serial data pin level
    output logic      SDA_O,                // serial data drive value
    output logic      SDA_OE_O,             // high while pulling data low
    input  wire logic WP_I,                 // write protect pin
    input  wire logic CLIENT_SELECT_HI_I,   // upper client select pin
    input  wire logic CLIENT_SELECT_LO_I,   // lower client select pin
    output logic      BUSY_O                // programming cycle running
);
    localparam int unsigned UP    = ADDR_W - eepr_pkg::BYTE_W;  // upper address bits
    localparam int unsigned DEPTH = 1 << ADDR_W;                // array bytes

    // pin synchronisers: scl, sda, wp, select hi, select lo
    logic [4:0] pin_meta_reg;    // first stage, read only by second
    logic [4:0] pin_sync_reg;    // second stage
    logic [1:0] bus_prev_reg;    // previous scl, sda for edges
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            pin_meta_reg <= 5'h03;
            pin_sync_reg <= 5'h03;
            bus_prev_reg <= 2'h3;
        end else begin
            pin_meta_reg <= {CLIENT_SELECT_LO_I, CLIENT_SELECT_HI_I, WP_I, SDA_I, SCL_I};
            pin_sync_reg <= pin_meta_reg;
            bus_prev_reg <= pin_sync_reg[1:0];
        end
    end

    logic scl_s, sda_s, wp_s;           // synchronised levels
    logic [1:0] sel_s;                  // {hi, lo} select levels
    logic start_ev, stop_ev, rise, fall;
    assign scl_s    = pin_sync_reg[0];
    assign sda_s    = pin_sync_reg[1];
    assign wp_s     = pin_sync_reg[2];
    assign sel_s    = {pin_sync_reg[3], pin_sync_reg[4]};
    // start: data falls with clock high; stop: data rises with clock high
    assign start_ev = scl_s && bus_prev_reg[0] && bus_prev_reg[1] && !sda_s;
    assign stop_ev  = scl_s && bus_prev_reg[0] && !bus_prev_reg[1] && sda_s;
    assign rise     = scl_s && !bus_prev_reg[0];
    assign fall     = !scl_s && bus_prev_reg[0];

    // programming timer
    eepr_tmr_if tmr_bus ();
    eepr_prog_timer #(.CYCLES(PROG_CYCLES)) u_timer (
        .clk_i (SYS_CLK_I),
        .rst_i (RST_I),
        .tmr   (tmr_bus.tmr)
    );
    logic busy;                         // array locked for programming
    assign busy = tmr_bus.busy;

    // storage
    logic [7:0] mem [0:DEPTH-1];                        // the array
    logic [7:0] pbuf [0:eepr_pkg::PAGE_BYTES-1];        // loaded page bytes
    logic       pbuf_we;                                // store received byte
    logic [3:0] pbuf_idx;                               // its page slot

    // engine state
    eepr_pkg::eepr_state_e state_reg, state_next;
    eepr_pkg::eepr_kind_e  kind_reg, kind_next;
    logic [3:0]        cnt_reg, cnt_next;       // bits in current byte
    logic [7:0]        sh_reg, sh_next;         // received bits
    logic [7:0]        tx_reg, tx_next;         // bits to send
    logic              rw_reg, rw_next;         // frame direction
    logic              ackin_reg, ackin_next;   // host acknowledged
    logic              oe_reg, oe_next;         // pull data low
    logic [UP-1:0]     up_reg, up_next;         // upper bits from address byte
    logic [ADDR_W-1:0] addr_reg, addr_next;     // address counter
    logic [ADDR_W-1:0] wa_reg, wa_next;         // page write pointer
    logic [4:0]        nbytes_reg, nbytes_next; // data bytes loaded
    logic [15:0]       mask_reg, mask_next;     // loaded page slots
    logic [ADDR_W-5:0] row_reg, row_next;       // row being programmed
    logic              match;                   // address byte is ours
    logic              dec_dev, dec_word, dec_data, load_ev;  // decision strobes

    // address byte compare: type pattern and select bits above the word bits
    always_comb begin
        match = (sh_reg[7:eepr_pkg::TYPE_LSB] == eepr_pkg::DEV_TYPE);
        for (int i = UP + 1; i <= eepr_pkg::SEL_MSB; i++) begin
            if (sh_reg[i] != sel_s[i-2]) begin
                match = 1'b0;
            end
        end
    end

    // byte engine next state
    always_comb begin
        state_next  = state_reg;
        kind_next   = kind_reg;
        cnt_next    = cnt_reg;
        sh_next     = sh_reg;
        tx_next     = tx_reg;
        rw_next     = rw_reg;
        ackin_next  = ackin_reg;
        oe_next     = oe_reg;
        up_next     = up_reg;
        addr_next   = addr_reg;
        wa_next     = wa_reg;
        nbytes_next = nbytes_reg;
        mask_next   = mask_reg;
        row_next    = row_reg;
        tmr_bus.start = 1'b0;
        pbuf_we     = 1'b0;
        pbuf_idx    = wa_reg[3:0];
        dec_dev     = 1'b0;
        dec_word    = 1'b0;
        dec_data    = 1'b0;
        load_ev     = 1'b0;
        if (stop_ev) begin
            // stop ends any frame; a write with data and no protect programs
            state_next = eepr_pkg::ST_IDLE;
            oe_next    = 1'b0;
            kind_next  = eepr_pkg::K_DEV;
            if (kind_reg == eepr_pkg::K_DATA && nbytes_reg != 5'h00 && !wp_s && !busy) begin
                tmr_bus.start = 1'b1;
                row_next      = wa_reg[ADDR_W-1:eepr_pkg::PAGE_BITS];
            end
        end else if (start_ev) begin
            // start or repeated start: expect an address byte
            state_next = eepr_pkg::ST_RX;
            kind_next  = eepr_pkg::K_DEV;
            cnt_next   = 4'h0;
            oe_next    = 1'b0;
        end else begin
            unique case (state_reg)
                eepr_pkg::ST_IDLE: begin
                    oe_next = 1'b0;
                end
                eepr_pkg::ST_RX: begin
                    if (rise) begin
                        sh_next  = {sh_reg[6:0], sda_s};
                        cnt_next = cnt_reg + 4'h1;
                    end else if (fall && cnt_reg == eepr_pkg::BIT_DONE) begin
                        cnt_next = 4'h0;
                        if (kind_reg == eepr_pkg::K_DEV) begin
                            dec_dev = 1'b1;
                            if (match && !busy) begin
                                oe_next    = 1'b1;
                                rw_next    = sh_reg[eepr_pkg::RW_BIT];
                                state_next = eepr_pkg::ST_ACKO;
                                if (!sh_reg[eepr_pkg::RW_BIT]) begin
                                    up_next = sh_reg[UP:1];
                                end
                            end else begin
                                state_next = eepr_pkg::ST_IDLE;
                            end
                        end else if (kind_reg == eepr_pkg::K_WORD) begin
                            // word byte: counter and page pointer start here
                            dec_word    = 1'b1;
                            addr_next   = {up_reg, sh_reg};
                            wa_next     = {up_reg, sh_reg};
                            nbytes_next = 5'h00;
                            mask_next   = 16'h0000;
                            kind_next   = eepr_pkg::K_DATA;
                            oe_next     = 1'b1;
                            state_next  = eepr_pkg::ST_ACKO;
                        end else begin
                            // data byte into page slot, pointer wraps inside page
                            dec_data    = 1'b1;
                            pbuf_we     = 1'b1;
                            mask_next[wa_reg[3:0]] = 1'b1;
                            wa_next     = {wa_reg[ADDR_W-1:4], wa_reg[3:0] + 4'h1};
                            addr_next   = {wa_reg[ADDR_W-1:4], wa_reg[3:0] + 4'h1};
                            if (nbytes_reg != 5'h10) begin
                                nbytes_next = nbytes_reg + 5'h01;
                            end
                            oe_next     = 1'b1;
                            state_next  = eepr_pkg::ST_ACKO;
                        end
                    end
                end
                eepr_pkg::ST_ACKO: begin
                    if (fall) begin
                        oe_next    = 1'b0;
                        state_next = eepr_pkg::ST_RX;
                        if (kind_reg == eepr_pkg::K_DEV) begin
                            if (rw_reg) begin
                                // read: first byte at the counter, msb first
                                load_ev    = 1'b1;
                                tx_next    = mem[addr_reg];
                                oe_next    = !mem[addr_reg][7];
                                addr_next  = addr_reg + 1'b1;
                                cnt_next   = 4'h0;
                                state_next = eepr_pkg::ST_TX;
                            end else begin
                                kind_next = eepr_pkg::K_WORD;
                            end
                        end
                    end
                end
                eepr_pkg::ST_TX: begin
                    if (rise) begin
                        cnt_next = cnt_reg + 4'h1;
                    end else if (fall) begin
                        if (cnt_reg == eepr_pkg::BIT_DONE) begin
                            oe_next    = 1'b0;
                            state_next = eepr_pkg::ST_ACKI;
                        end else begin
                            tx_next = {tx_reg[6:0], 1'b0};
                            oe_next = !tx_reg[6];
                        end
                    end
                end
                eepr_pkg::ST_ACKI: begin
                    if (rise) begin
                        ackin_next = !sda_s;
                    end else if (fall) begin
                        if (ackin_reg) begin
                            // host ack: next byte, wrapping over the whole array
                            load_ev    = 1'b1;
                            tx_next    = mem[addr_reg];
                            oe_next    = !mem[addr_reg][7];
                            addr_next  = addr_reg + 1'b1;
                            cnt_next   = 4'h0;
                            state_next = eepr_pkg::ST_TX;
                        end else begin
                            state_next = eepr_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_next = eepr_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // engine registers; the counter keeps its value between frames
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            state_reg  <= eepr_pkg::ST_IDLE;
            kind_reg   <= eepr_pkg::K_DEV;
            cnt_reg    <= 4'h0;
            sh_reg     <= 8'h00;
            tx_reg     <= 8'h00;
            rw_reg     <= 1'b0;
            ackin_reg  <= 1'b0;
            oe_reg     <= 1'b0;
            up_reg     <= '0;
            addr_reg   <= '0;
            wa_reg     <= '0;
            nbytes_reg <= 5'h00;
            mask_reg   <= 16'h0000;
            row_reg    <= '0;
        end else begin
            state_reg  <= state_next;
            kind_reg   <= kind_next;
            cnt_reg    <= cnt_next;
            sh_reg     <= sh_next;
            tx_reg     <= tx_next;
            rw_reg     <= rw_next;
            ackin_reg  <= ackin_next;
            oe_reg     <= oe_next;
            up_reg     <= up_next;
            addr_reg   <= addr_next;
            wa_reg     <= wa_next;
            nbytes_reg <= nbytes_next;
            mask_reg   <= mask_next;
            row_reg    <= row_next;
        end
    end

    // page buffer load and array commit at the end of the cycle
    always_ff @(posedge SYS_CLK_I) begin
        if (pbuf_we) begin
            pbuf[pbuf_idx] <= sh_reg;
        end
        if (tmr_bus.done) begin
            for (int i = 0; i < eepr_pkg::PAGE_BYTES; i++) begin
                if (mask_reg[i]) begin
                    mem[{row_reg, 4'(i)}] <= pbuf[i];
                end
            end
        end
    end

    assign SDA_O    = 1'b0;     // open drain: only ever pulls low
    assign SDA_OE_O = oe_reg;
    assign BUSY_O   = busy;

    // checks, all on the system clock
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);

    sequence s_dev_busy;
        dec_dev && busy;
    endsequence
    sequence s_prog_stop;
        stop_ev && kind_reg == eepr_pkg::K_DATA && nbytes_reg != 5'h00 && !busy;
    endsequence

    busy_no_ack_a: assert property (s_dev_busy |=> !oe_reg && state_reg == eepr_pkg::ST_IDLE)
        else $error("address acknowledged while programming");
    type_match_a: assert property (dec_dev && !match |=> !oe_reg[*2])
        else $error("foreign address byte acknowledged");
    prog_start_a: assert property ((s_prog_stop and !wp_s) |=> busy)
        else $error("stop after data did not start programming");
    protect_skip_a: assert property ((s_prog_stop and wp_s) |=> !busy)
        else $error("protected write started programming");
    no_data_a: assert property (stop_ev && nbytes_reg == 5'h00 && !busy |=> !busy)
        else $error("stop without data started programming");
    page_wrap_a: assert property (dec_data |=> wa_reg[ADDR_W-1:4] == $past(wa_reg[ADDR_W-1:4])
        && wa_reg[3:0] == $past(wa_reg[3:0]) + 4'h1)
        else $error("page pointer left its row");
    word_addr_a: assert property (dec_word |=> addr_reg == {$past(up_reg), $past(sh_reg)})
        else $error("word address not loaded");
    read_step_a: assert property (load_ev |=> addr_reg == $past(addr_reg) + 1'b1 ##0 oe_reg == !tx_reg[7])
        else $error("read counter or first bit wrong");
    wp_hold_a: assert property (busy && $changed(wp_s) |=> busy || tmr_bus.done)
        else $error("programming aborted early");
endmodule // eepr_top

// File: rtl/eepr_pkg.sv
// constants and types shared by the serial eeprom command logic
// Functional notes
// - 9-bit or 10-bit word address by variant
// - ack each byte; stop starts programming
// - ignore the bus while programming runs
// - one cycle writes 1..16 bytes, one row
// - page write takes up to fifteen more bytes
// - only low four address bits increment
// - page address wraps within the same page
// - address polling gets no ack while busy
// - no array access during the write cycle
// - protect input high protects whole array
// - protect input sampled at the stop only
// - protected write acked but never programmed
// - counter keeps last address plus one
// - read past last byte wraps to zero
// - read sends counter byte, msb first
// - host nack ends read; stop or start follows
// - read address byte word bits ignored
// - host ack advances to next byte
// - type pattern, selects, direction bit layout
// - ack only matching device address bytes
// - word byte gives low eight address bits
package eepr_pkg;
    localparam int unsigned CLK_PERIOD_NS  = 25;       // system clock period
    localparam int unsigned PROG_TIME_US   = 1000;     // program_cycle_time, plain default
    localparam int unsigned PROG_CYCLES    = (PROG_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned ADDR_W_DEF     = 9;        // word address width, small variant
    localparam int unsigned BYTE_W         = 8;        // bits per byte
    localparam int unsigned PAGE_BITS      = 4;        // byte index bits inside a page
    localparam int unsigned PAGE_BYTES     = 16;       // bytes per page
    localparam logic [3:0]  DEV_TYPE       = 4'ha;     // fixed type pattern
    localparam int unsigned TYPE_LSB       = 4;        // type pattern low bit
    localparam int unsigned SEL_MSB        = 3;        // highest select bit
    localparam int unsigned RW_BIT         = 0;        // direction bit
    localparam logic [3:0]  BIT_DONE       = 4'h8;     // bits per byte, as counter value

    // byte engine states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,   // waiting for a start
        ST_RX   = 3'b001,   // shifting a byte in
        ST_ACKO = 3'b010,   // device drives acknowledge
        ST_TX   = 3'b011,   // shifting a byte out
        ST_ACKI = 3'b100    // host acknowledge slot
    } eepr_state_e;

    // which byte of a frame is being received
    typedef enum logic [1:0] {
        K_DEV  = 2'b00,     // device address byte
        K_WORD = 2'b01,     // word address byte
        K_DATA = 2'b10      // write data byte
    } eepr_kind_e;
endpackage

// File: rtl/eepr_tmr_if.sv
// handshake between the byte engine and the programming timer
`timescale 1ns/1ps
interface eepr_tmr_if;
    logic start;   // one-cycle request to begin programming
    logic busy;    // programming cycle under way
    logic done;    // one-cycle pulse when the cycle ends
    modport ctrl (output start, input busy, input done);
    modport tmr  (input start, output busy, output done);
endinterface

// File: rtl/eepr_prog_timer.sv
// self-timed programming cycle counter
`timescale 1ns/1ps
module eepr_prog_timer #(
    parameter int unsigned CYCLES = eepr_pkg::PROG_CYCLES  // cycle length in clocks
) (
    input  wire logic clk_i,   // system clock
    input  wire logic rst_i,   // synchronous reset
    eepr_tmr_if.tmr   tmr      // engine handshake
);
    logic [31:0] cnt_reg, cnt_next;     // elapsed clocks
    logic        busy_reg, busy_next;   // cycle running
    logic        done_reg, done_next;   // end pulse

    // next state: a start during a cycle is ignored, so it cannot abort
    always_comb begin
        cnt_next  = cnt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        if (busy_reg) begin
            if (cnt_reg == CYCLES - 1) begin
                busy_next = 1'b0;
                done_next = 1'b1;
                cnt_next  = 32'h0000_0000;
            end else begin
                cnt_next = cnt_reg + 32'h0000_0001;
            end
        end else if (tmr.start) begin
            busy_next = 1'b1;
            cnt_next  = 32'h0000_0000;
        end
    end

    // registers only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg  <= 32'h0000_0000;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    assign tmr.busy = busy_reg;
    assign tmr.done = done_reg;

    // the end pulse comes exactly after the full count
    cycle_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
        done_reg |-> !busy_reg && $past(busy_reg) && $past(cnt_reg) == CYCLES - 1)
        else $error("programming cycle ended at wrong count");
endmodule // eepr_prog_timer

// File: testbench/eepr_host_model.sv
// two-wire bus host model stepped by the link clock
`timescale 1ns/1ps
module eepr_host_model (
    input  wire logic lclk_i,    // link clock
    input  wire logic sda_i,     // resolved data wire
    output logic      scl_o,     // serial clock, still outside frames
    output logic      sda_low_o  // high while pulling data low
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // one bus phase of three link clocks
    task automatic ph();
        repeat (3) @(posedge lclk_i);
    endtask
    // start or repeated start
    task automatic start_c();
        sda_low_o <= 1'b0;
        ph();
        scl_o <= 1'b1;
        ph();
        sda_low_o <= 1'b1;
        ph();
        scl_o <= 1'b0;
        ph();
    endtask
    // stop, data rises while clock high
    task automatic stop_c();
        sda_low_o <= 1'b1;
        ph();
        scl_o <= 1'b1;
        ph();
        sda_low_o <= 1'b0;
        ph();
    endtask
    // one bit, data only moves while clock low
    task automatic bit_x(input logic b, output logic got);
        sda_low_o <= ~b;
        ph();
        scl_o <= 1'b1;
        ph();
        got = sda_i;
        ph();
        scl_o <= 1'b0;
        ph();
    endtask
    // byte out msb first, returns device ack
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) bit_x(d[i], g);
        bit_x(1'b1, g);
        ack = ~g;
    endtask
    // byte in, host ack or nack on ninth clock
    task automatic rd_byte(input logic ack, output logic [7:0] d);
        logic g;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(~ack, g);
    endtask
endmodule // eepr_host_model

// File: testbench/eepr_top_test.sv
// self-checking bench for the serial eeprom command engine
`timescale 1ns/1ps
module eepr_top_test;
    localparam int PROG = 1000;        // shortened programming length
    logic       sys_clk = 1'b0;        // system clock
    logic       lclk    = 1'b0;        // link clock
    logic       rst     = 1'b1;        // reset
    logic       wp      = 1'b0;        // write protect
    logic       sel_hi  = 1'b0;        // select straps
    logic       sel_lo  = 1'b0;
    wire        scl, host_low, sda, oe, sda_o, busy;
    int         mismatches = 0;
    int         total_checks = 0;
    logic [7:0] mem [512];             // expected array
    logic [8:0] ptr;                   // expected address counter
    always #12.5 sys_clk = ~sys_clk;
    always #40 lclk = ~lclk;
    // pulled-up wire from both drivers
    assign sda = ~(oe & ~sda_o) & ~host_low;
    eepr_top #(.ADDR_W(9), .PROG_CYCLES(PROG)) eepr_top_i (.SYS_CLK_I(sys_clk), .RST_I(rst), .SCL_I(scl),
        .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(oe), .WP_I(wp), .CLIENT_SELECT_HI_I(sel_hi),
        .CLIENT_SELECT_LO_I(sel_lo), .BUSY_O(busy));
    eepr_host_model eepr_host_model_i (.lclk_i(lclk), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));
    // compare and count
    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // device address byte for this device
    function automatic logic [7:0] dev(input logic [8:0] a, input logic rd);
        return {4'ha, sel_hi, sel_lo, a[8], rd};
    endfunction
    // write frame of n data bytes, then stop
    task automatic write_run(input logic [8:0] a, input int n);
        logic ack;
        logic [7:0] d;
        logic [3:0] slot;
        slot = a[3:0];
        eepr_host_model_i.start_c();
        eepr_host_model_i.wr_byte(dev(a, 1'b0), ack);
        check("dev ack", ack, 1);
        eepr_host_model_i.wr_byte(a[7:0], ack);
        check("word ack", ack, 1);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            eepr_host_model_i.wr_byte(d, ack);
            check("data ack", ack, 1);
            if (!wp) mem[{a[8:4], slot}] = d;
            slot++;
        end
        eepr_host_model_i.stop_c();
        ptr = {a[8:4], slot};
        check("busy", busy, 10'(n > 0 && !wp));
    endtask
    // read refused while busy, then poll until acked
    task automatic poll();
        logic ack;
        eepr_host_model_i.start_c();
        eepr_host_model_i.wr_byte(dev(ptr, 1'b1), ack);
        check("busy nack", ack, 0);
        for (int i = 0; i < 20 && !ack; i++) begin
            eepr_host_model_i.start_c();
            eepr_host_model_i.wr_byte(dev(ptr, 1'b0), ack);
        end
        check("poll ack", ack, 1);
        check("ready", busy, 0);
        eepr_host_model_i.stop_c();
    endtask
    // random or current address read of n bytes
    task automatic read_run(input logic dummy, input logic [8:0] a, input int n);
        logic ack;
        logic [7:0] d;
        if (dummy) begin
            eepr_host_model_i.start_c();
            eepr_host_model_i.wr_byte(dev(a, 1'b0), ack);
            eepr_host_model_i.wr_byte(a[7:0], ack);
            ptr = a;
        end
        eepr_host_model_i.start_c();
        eepr_host_model_i.wr_byte(dev(ptr ^ 9'h100, 1'b1), ack);
        check("read ack", ack, 1);
        for (int i = 0; i < n; i++) begin
            eepr_host_model_i.rd_byte(i < n - 1, d);
            check("read data", d, mem[ptr]);
            ptr++;
        end
        eepr_host_model_i.stop_c();
    endtask
    // main sequence
    initial begin
        logic ack;
        void'($urandom(48));
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        {sel_hi, sel_lo} = 2'($urandom);
        check("reset outs", {oe, busy}, 0);
        repeat (4) @(posedge sys_clk);
        write_run(9'h1f0, 17);
        poll();
        eepr_host_model_i.start_c();
        eepr_host_model_i.wr_byte({4'ha, ~sel_hi, sel_lo, 2'b00}, ack);
        check("foreign nack", ack, 0);
        eepr_host_model_i.stop_c();
        read_run(1'b0, 9'h000, 15);
        $display("test page wrap done");
        @(negedge sys_clk);
        wp = 1'b1;
        write_run(9'h1f5, 1);
        @(negedge sys_clk);
        wp = 1'b0;
        write_run(9'h000, 2);
        @(negedge sys_clk);
        wp = 1'b1;
        poll();
        @(negedge sys_clk);
        wp = 1'b0;
        $display("test protect done");
        read_run(1'b1, 9'h1ff, 3);
        read_run(1'b1, 9'h1f5, 1);
        write_run(9'h1f0, 0);
        read_run(1'b0, 9'h000, 1);
        $display("test reads done");
        summarize();
    end
    // watchdog, about two and a half times the expected run length
    initial begin
        #1500000;
        mismatches++;
        summarize();
    end
endmodule // eepr_top_test
